/* logic/mcc_pkg.sv */
package mcc_pkg;
    // ----------------------------------------------------------------
    // Source selection and prescaler encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_HFO = 2'h0;
    localparam logic [1:0] SEL_LPO = 2'h1;
    localparam logic [1:0] SEL_EXT = 2'h3;
    localparam logic [1:0] SEL_RESET = SEL_HFO;
    localparam logic [3:0] PDIV_RESET = 4'h8;
    localparam logic PEN_RESET = 1'b1;
    localparam int NUM_DIV = 12;

    // ----------------------------------------------------------------
    // Timing: protected window and start-up counts
    // ----------------------------------------------------------------
    localparam logic [2:0] PROT_WINDOW = 3'h4;
    localparam logic [2:0] HFO_START_CYC = 3'h4;
    localparam logic [2:0] LPO_START_CYC = 3'h4;
    localparam logic [2:0] EXT_START_CYC = 3'h2;
    localparam logic [2:0] EXT_EDGES_NEEDED = 3'h4;

    // ----------------------------------------------------------------
    // Sleep modes and switch states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SLP_ACTIVE = 2'b00,
        SLP_IDLE = 2'b01,
        SLP_STANDBY = 2'b10,
        SLP_PDOWN = 2'b11
    } mcc_sleep_e;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT_EDGES = 2'b01,
        SW_SAFE_POINT = 2'b10
    } mcc_sw_e;
endpackage

/* logic/mcc_osc_ctl.sv */
`timescale 1ns/1ps
module mcc_osc_ctl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Demand and configuration
    input wire logic request,
    input wire logic run_in_standby,
    input wire logic power_down,
    input wire logic [2:0] start_cycles,
    // Oscillator control and status
    output logic osc_enable,
    output logic osc_stable
);
    logic [2:0] cnt_q;
    logic stable_q;
    logic want;

    // Runs when requested, or forced by standby bit outside power-down
    assign want = request | (run_in_standby & ~power_down);
    assign osc_enable = want;

    // Start-up counter; stable only after the counted cycles
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_q <= 3'h0;
            stable_q <= 1'b0;
        end else if (clk_en) begin
            if (!want) begin
                cnt_q <= 3'h0;
                stable_q <= 1'b0;
            end else if (cnt_q < start_cycles) begin
                cnt_q <= cnt_q + 3'h1;
            end else begin
                stable_q <= 1'b1;
            end
        end
    end

    assign osc_stable = stable_q;
endmodule

/* logic/mcc_prescaler.sv */
`timescale 1ns/1ps
module mcc_prescaler (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Configuration
    input wire logic main_run,
    input wire logic pen,
    input wire logic [3:0] pdiv,
    // Peripheral clock enable pulse
    output logic per_tick
);
    logic [5:0] cnt_q;
    logic [5:0] limit;
    logic [5:0] div_tab [mcc_pkg::NUM_DIV];
    logic tick_q;

    // Terminal counts (factor minus one), so divide-by-64 fits six bits
    assign div_tab = '{6'h01, 6'h03, 6'h07, 6'h0f, 6'h1f, 6'h3f,
        6'h05, 6'h09, 6'h05, 6'h0b, 6'h17, 6'h2f};

    // Terminal count; divide-by-one when disabled
    assign limit = !pen ? 6'h00 : (pdiv < 4'hc) ? div_tab[pdiv] : 6'h01;

    // Count main clock cycles and pulse once per period
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_q <= 6'h00;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            tick_q <= main_run && (cnt_q >= limit);
            if (main_run) begin
                cnt_q <= (cnt_q >= limit) ? 6'h00 : cnt_q + 6'h01;
            end
        end
    end

    assign per_tick = tick_q;
endmodule

/* logic/mcc_clock_controller.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Sources with no request and no standby force are switched off.
// - Standby bit keeps oscillator running except in power-down.
// - Main clock runs in active/idle; in standby only on demand or bit.
// - Power-down stops main clock only after memory operations finish.
// - Any internal oscillator can be selected as main source at run time.
// - External switch completes after enough edges; old clock keeps running.
// - While waiting for external edges, further selects ignored until the edges are counted or reset.
// - Switch-in-progress flag high while a source change is pending.
// - External-clock-stable flag shows enough edges seen since the pin source was enabled.
// - No automatic fallback on external failure; watchdog reset recovers.
// - Prescaler divides main clock; twelve settings from two to sixty-four, divide-by-one when disabled.
// - Reset selects high-frequency oscillator, prescaler divides by six.
// - Main control and prescaler written only through protected sequence.
// - Internal sources enabled automatically when any peripheral requests.
// - Status bit per oscillator shows it running and stable.
// - Prescaled peripheral clock feeds processor and peripheral clock enables.
// - Real-time clock requested when counter or periodic timer enabled.
// - Watchdog clock on watchdog enable; brown-out clock in sampled mode.
// - Main source from select field; async sources set in peripherals.
// - External pin clock usable after a two-cycle start and four counted edges.
// - High-frequency oscillator stable after start-up plus four cycles.
module mcc_clock_controller (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Processor write port for protected registers
    input wire logic key_write,
    input wire logic instr_done,
    input wire logic ctrl_write,
    input wire logic [1:0] wr_source_select,
    input wire logic wr_clock_output_pin_en,
    input wire logic presc_write,
    input wire logic [3:0] wr_pdiv,
    input wire logic wr_pen,
    // Unprotected run-in-standby bits
    input wire logic hfo_run_in_standby,
    input wire logic lpo_run_in_standby,
    // Sleep and memory controller
    input wire logic [1:0] sleep_mode,
    input wire logic nvm_busy,
    // Peripheral clock requests
    input wire logic hfo_periph_req,
    input wire logic ext_periph_req,
    input wire logic rtc_enabled,
    input wire logic pit_enabled,
    input wire logic rtc_uses_ext,
    input wire logic watchdog_enabled,
    input wire logic brownout_enabled,
    input wire logic brownout_sampled,
    // External clock pin (asynchronous)
    input wire logic ext_clk_pin,
    // Oscillator enables
    output logic hfo_enable,
    output logic lpo_enable,
    output logic ext_pin_clock_mode,
    // Asynchronous clock requests
    output logic rtc_clock_req,
    output logic watchdog_clock_req,
    output logic brownout_clock_req,
    // Main clock routing
    output logic [1:0] main_source_active,
    output logic main_clock_run,
    output logic cpu_clock_en,
    output logic per_clock_en,
    // Clock output pin
    output logic clock_output_pin,
    output logic clock_output_oe,
    // Register read-back and status
    output logic [1:0] main_source_select,
    output logic clock_output_pin_enable,
    output logic [3:0] presc_div,
    output logic presc_en,
    output logic switch_in_progress,
    output logic external_clock_stable,
    output logic hfo_stable,
    output logic lpo_stable
);
    // ----------------------------------------------------------------
    // Protected write window
    // ----------------------------------------------------------------
    logic [2:0] win_q;
    logic [2:0] win_d;
    logic unlocked;

    assign unlocked = (win_q != 3'h0);

    // Key opens the window; each retired instruction closes it by one
    always_comb begin
        win_d = win_q;
        if (key_write) begin
            win_d = mcc_pkg::PROT_WINDOW;
        end else if (instr_done && unlocked) begin
            win_d = win_q - 3'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            win_q <= 3'h0;
        end else if (clk_en) begin
            win_q <= win_d;
        end
    end

    // ----------------------------------------------------------------
    // External pin synchroniser and edge counter
    // ----------------------------------------------------------------
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic ext_edge;
    logic [2:0] edge_cnt_q;
    logic edges_ok;

    // Second and third stages feed edge detection, first stage stays clean
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else if (clk_en) begin
            ext_s1_q <= ext_clk_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    assign ext_edge = ext_s2_q & ~ext_s3_q;
    assign edges_ok = (edge_cnt_q >= mcc_pkg::EXT_EDGES_NEEDED);

    // ----------------------------------------------------------------
    // Protected registers
    // ----------------------------------------------------------------
    logic [1:0] sel_q;
    logic clock_output_pin_q;
    logic [3:0] pdiv_q;
    logic pen_q;
    logic sel_take;
    logic presc_take;
    mcc_pkg::mcc_sw_e sw_q;
    mcc_pkg::mcc_sw_e sw_d;
    logic [1:0] active_q;
    logic [1:0] active_d;

    // Writes land only inside the window; selects frozen while waiting
    assign sel_take = ctrl_write && unlocked && (sw_q != mcc_pkg::SW_WAIT_EDGES);
    assign presc_take = presc_write && unlocked;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sel_q <= mcc_pkg::SEL_RESET;
            clock_output_pin_q <= 1'b0;
            pdiv_q <= mcc_pkg::PDIV_RESET;
            pen_q <= mcc_pkg::PEN_RESET;
        end else if (clk_en) begin
            if (sel_take) begin
                sel_q <= wr_source_select;
            end
            if (ctrl_write && unlocked) begin
                clock_output_pin_q <= wr_clock_output_pin_en;
            end
            if (presc_take) begin
                pdiv_q <= wr_pdiv;
                pen_q <= wr_pen;
            end
        end
    end

    // ----------------------------------------------------------------
    // Oscillator demand and control
    // ----------------------------------------------------------------
    logic pdown;
    logic standby;
    logic main_on;
    logic hfo_req;
    logic lpo_req;
    logic ext_req;
    logic hfo_en;
    logic lpo_en;
    logic ext_en;
    logic ext_ok;

    assign pdown = (sleep_mode == mcc_pkg::SLP_PDOWN);
    assign standby = (sleep_mode == mcc_pkg::SLP_STANDBY);

    // Async clock requests come straight from peripheral enables
    assign rtc_clock_req = rtc_enabled | pit_enabled;
    assign watchdog_clock_req = watchdog_enabled;
    assign brownout_clock_req = brownout_enabled & brownout_sampled;

    // Route each request to its source; main clock demand adds the active and selected sources
    assign hfo_req = hfo_periph_req | (main_on && (active_q == mcc_pkg::SEL_HFO ||
        sel_q == mcc_pkg::SEL_HFO));
    assign lpo_req = rtc_clock_req | watchdog_clock_req | brownout_clock_req
        | (main_on && (active_q == mcc_pkg::SEL_LPO || sel_q == mcc_pkg::SEL_LPO));
    assign ext_req = ext_periph_req | (rtc_clock_req & rtc_uses_ext)
        | (main_on && (active_q == mcc_pkg::SEL_EXT || sel_q == mcc_pkg::SEL_EXT));

    mcc_osc_ctl u_hfo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .request(hfo_req),
        .run_in_standby(hfo_run_in_standby),
        .power_down(pdown),
        .start_cycles(mcc_pkg::HFO_START_CYC),
        .osc_enable(hfo_en),
        .osc_stable(hfo_stable)
    );

    mcc_osc_ctl u_lpo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .request(lpo_req),
        .run_in_standby(lpo_run_in_standby),
        .power_down(pdown),
        .start_cycles(mcc_pkg::LPO_START_CYC),
        .osc_enable(lpo_en),
        .osc_stable(lpo_stable)
    );

    // External source has no standby bit; two-cycle start on request
    mcc_osc_ctl u_ext (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .request(ext_req),
        .run_in_standby(1'b0),
        .power_down(pdown),
        .start_cycles(mcc_pkg::EXT_START_CYC),
        .osc_enable(ext_en),
        .osc_stable(ext_ok)
    );

    assign hfo_enable = hfo_en;
    assign lpo_enable = lpo_en;
    assign ext_pin_clock_mode = ext_en;
    assign external_clock_stable = ext_ok & edges_ok;

    // Edge counter restarts whenever the pin source is not wanted
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            edge_cnt_q <= 3'h0;
        end else if (clk_en) begin
            if (!ext_en) begin
                edge_cnt_q <= 3'h0;
            end else if (ext_edge && !edges_ok) begin
                edge_cnt_q <= edge_cnt_q + 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Main clock run control across sleep modes
    // ----------------------------------------------------------------
    logic src_rsb;

    assign src_rsb = (active_q == mcc_pkg::SEL_HFO) ? hfo_run_in_standby :
        (active_q == mcc_pkg::SEL_LPO) ? lpo_run_in_standby : 1'b0;

    // Power-down holds the clock until memory work drains
    assign main_on = pdown ? nvm_busy :
        standby ? (hfo_periph_req | ext_periph_req | src_rsb) :
        1'b1;

    // ----------------------------------------------------------------
    // Source switch sequencer
    // ----------------------------------------------------------------
    logic target_ready;

    assign target_ready = (sel_q == mcc_pkg::SEL_HFO) ? hfo_stable :
        (sel_q == mcc_pkg::SEL_LPO) ? lpo_stable :
        (sel_q == mcc_pkg::SEL_EXT) ? external_clock_stable : 1'b0;

    // No fallback path: a dead external source just stalls here
    always_comb begin
        sw_d = sw_q;
        active_d = active_q;
        case (sw_q)
            mcc_pkg::SW_IDLE: begin
                if (sel_q != active_q) begin
                    sw_d = (sel_q == mcc_pkg::SEL_EXT) ? mcc_pkg::SW_WAIT_EDGES :
                        mcc_pkg::SW_SAFE_POINT;
                end
            end
            mcc_pkg::SW_WAIT_EDGES: begin
                if (external_clock_stable) begin
                    sw_d = mcc_pkg::SW_SAFE_POINT;
                end
            end
            mcc_pkg::SW_SAFE_POINT: begin
                if (target_ready && per_clock_en) begin
                    active_d = sel_q;
                    sw_d = mcc_pkg::SW_IDLE;
                end
            end
            default: begin
                sw_d = mcc_pkg::SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sw_q <= mcc_pkg::SW_IDLE;
            active_q <= mcc_pkg::SEL_RESET;
        end else if (clk_en) begin
            sw_q <= sw_d;
            active_q <= active_d;
        end
    end

    assign switch_in_progress = (sw_q != mcc_pkg::SW_IDLE) || (sel_q != active_q);

    // ----------------------------------------------------------------
    // Prescaler and distribution
    // ----------------------------------------------------------------
    logic per_tick;

    mcc_prescaler u_presc (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .main_run(main_on),
        .pen(pen_q),
        .pdiv(pdiv_q),
        .per_tick(per_tick)
    );

    assign per_clock_en = per_tick;
    assign cpu_clock_en = per_tick;
    assign main_clock_run = main_on;
    assign main_source_active = active_q;

    // Clock output toggles per peripheral period, gated by enable
    logic clock_output_pin_pin_q;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clock_output_pin_pin_q <= 1'b0;
        end else if (clk_en) begin
            if (!clock_output_pin_q) begin
                clock_output_pin_pin_q <= 1'b0;
            end else if (per_tick) begin
                clock_output_pin_pin_q <= ~clock_output_pin_pin_q;
            end
        end
    end

    assign clock_output_pin = clock_output_pin_pin_q;
    assign clock_output_oe = clock_output_pin_q;

    // Register read-back
    assign main_source_select = sel_q;
    assign clock_output_pin_enable = clock_output_pin_q;
    assign presc_div = pdiv_q;
    assign presc_en = pen_q;
endmodule

/* verif/mcc_ext_src.sv */
`timescale 1ns/1ps
module mcc_ext_src (
    // Control
    input wire logic run,
    // Clock pin
    output logic ext_clk_pin
);
    // Period is unrelated to ref_clk; the pin rests low while stopped
    initial ext_clk_pin = 1'b0;
    always #137 ext_clk_pin = run ? ~ext_clk_pin : 1'b0;
endmodule

/* verif/mcc_chk_asserts.sv */
`timescale 1ns/1ps
module mcc_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Protected writes
    input wire logic key_write,
    input wire logic instr_done,
    input wire logic ctrl_write,
    input wire logic [1:0] wr_source_select,
    input wire logic presc_write,
    input wire logic [3:0] wr_pdiv,
    input wire logic wr_pen,
    // Demand
    input wire logic lpo_run_in_standby,
    input wire logic [1:0] sleep_mode,
    input wire logic nvm_busy,
    input wire logic hfo_periph_req,
    input wire logic ext_periph_req,
    input wire logic rtc_enabled,
    input wire logic pit_enabled,
    input wire logic watchdog_enabled,
    input wire logic brownout_enabled,
    input wire logic brownout_sampled,
    // Outputs watched
    input wire logic hfo_enable,
    input wire logic lpo_enable,
    input wire logic ext_pin_clock_mode,
    input wire logic rtc_clock_req,
    input wire logic watchdog_clock_req,
    input wire logic brownout_clock_req,
    input wire logic [1:0] main_source_active,
    input wire logic main_clock_run,
    input wire logic clock_output_oe,
    input wire logic [1:0] main_source_select,
    input wire logic clock_output_pin_enable,
    input wire logic [3:0] presc_div,
    input wire logic presc_en,
    input wire logic switch_in_progress
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Key, then a write in the next cycle
    sequence s_key;
        key_write && clk_en;
    endsequence
    sequence s_key_ctrl;
        s_key ##1 (ctrl_write && clk_en && !instr_done
            && !(switch_in_progress && main_source_select == mcc_pkg::SEL_EXT));
    endsequence
    sequence s_key_presc;
        s_key ##1 (presc_write && clk_en && !instr_done);
    endsequence
    chk_ctrl_accept: assert property (
        s_key_ctrl |=> main_source_select == $past(wr_source_select))
        else $error("select write lost");
    chk_presc_accept: assert property (
        s_key_presc |=> presc_div == $past(wr_pdiv) && presc_en == $past(wr_pen))
        else $error("prescaler write lost");
    chk_ext_lock: assert property (
        switch_in_progress && main_source_select == mcc_pkg::SEL_EXT
        |=> main_source_select == mcc_pkg::SEL_EXT)
        else $error("select changed while locked");
    chk_pending_flag: assert property (
        main_source_select != main_source_active |-> switch_in_progress)
        else $error("pending switch without flag");
    chk_switch_done: assert property (
        $fell(switch_in_progress) |-> main_source_active == main_source_select)
        else $error("flag cleared before switch");
    chk_main_awake: assert property (
        sleep_mode < 2'h2 |-> main_clock_run)
        else $error("main clock stopped");
    chk_pdown_hold: assert property (
        sleep_mode == 2'h3 && nvm_busy |-> main_clock_run)
        else $error("clock stopped, memory busy");
    chk_lpo_standby: assert property (
        lpo_run_in_standby && sleep_mode != 2'h3 |-> lpo_enable)
        else $error("forced oscillator off");
    chk_hfo_demand: assert property (
        hfo_periph_req && sleep_mode != 2'h3 |-> hfo_enable)
        else $error("requested oscillator off");
    chk_ext_pin_mode: assert property (
        ext_periph_req |-> ext_pin_clock_mode)
        else $error("pin not in clock mode");
    chk_async_reqs: assert property (
        rtc_clock_req == (rtc_enabled || pit_enabled) && watchdog_clock_req == watchdog_enabled
        && brownout_clock_req == (brownout_enabled && brownout_sampled))
        else $error("async request wrong");
    chk_clock_output_pin_oe: assert property (
        clock_output_oe == clock_output_pin_enable)
        else $error("clock output enable wrong");
endmodule
bind mcc_clock_controller mcc_chk i_mcc_chk (.*);

/* verif/mcc_clock_controller_tb_top.sv */
`timescale 1ns/1ps
module mcc_clock_controller_tb_top;
    // ----
    // Signals
    // ----
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic key_write = 1'b0, instr_done = 1'b0, ctrl_write = 1'b0, wr_clock_output_pin_en = 1'b0;
    logic presc_write = 1'b0, wr_pen = 1'b0, nvm_busy = 1'b0, ext_run = 1'b0;
    logic [1:0] wr_source_select = 2'h0, sleep_mode = 2'h0, main_source_active, main_source_select;
    logic [3:0] wr_pdiv = 4'h0, presc_div;
    logic [9:0] dem = 10'h0;
    logic [16:0] lfsr = 17'h1711c;
    wire hfo_run_in_standby, lpo_run_in_standby, hfo_periph_req, ext_periph_req, rtc_enabled;
    wire pit_enabled, rtc_uses_ext, watchdog_enabled, brownout_enabled, brownout_sampled;
    logic ext_clk_pin, hfo_enable, lpo_enable, ext_pin_clock_mode, rtc_clock_req;
    logic watchdog_clock_req, brownout_clock_req, main_clock_run, cpu_clock_en, per_clock_en;
    logic clock_output_pin, clock_output_oe, clock_output_pin_enable, presc_en, switch_in_progress;
    logic external_clock_stable, hfo_stable, lpo_stable, v;
    int failures = 0, tests_run = 0, n, c;
    // One vector keeps random demand to one assignment
    assign {hfo_run_in_standby, lpo_run_in_standby, hfo_periph_req, ext_periph_req, rtc_enabled,
        pit_enabled, rtc_uses_ext, watchdog_enabled, brownout_enabled, brownout_sampled} = dem;
    always #25 ref_clk = ~ref_clk;
    mcc_clock_controller i_mcc_clock_controller (.*);
    mcc_ext_src i_mcc_ext_src (.run(ext_run), .ext_clk_pin(ext_clk_pin));
    // ----
    // Expectations and tasks
    // ----
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic int exp_div(input logic [3:0] code, input logic pen);
        int t [12] = '{2, 4, 8, 16, 32, 64, 6, 10, 6, 12, 24, 48};
        return pen ? t[code] : 1;
    endfunction
    // External pin serves its own requests and an RTC routed to it
    function automatic logic [3:0] exp_req(input logic [9:0] d);
        return {d[6] | ((d[5] | d[4]) & d[3]), d[5] | d[4], d[2], d[1] & d[0]};
    endfunction
    task conclude;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task hang(input string what);
        failures++;
        $display("mismatch at %0t: %s timed out", $time, what);
        conclude();
    endtask
    task check_val(input logic [3:0] got, input logic [3:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task check_cnt(input int got, input int exp, input string what);
        tests_run++;
        if (got != exp) begin
            failures++;
            $display("mismatch at %0t: %s got %0d", $time, what, got);
        end
    endtask
    // Key, then gap retired instructions, then one write strobe
    task prot(input logic is_ctrl, input logic [1:0] sel, input logic ce, input logic [3:0] pd,
        input logic pe, input int gap);
        int i;
        @(posedge ref_clk);
        key_write <= 1'b1;
        @(posedge ref_clk);
        key_write <= 1'b0;
        for (i = 0; i < gap; i++) begin
            instr_done <= 1'b1;
            @(posedge ref_clk);
        end
        instr_done <= 1'b0;
        ctrl_write <= is_ctrl;
        presc_write <= !is_ctrl;
        wr_source_select <= sel;
        wr_clock_output_pin_en <= ce;
        wr_pdiv <= pd;
        wr_pen <= pe;
        @(posedge ref_clk);
        ctrl_write <= 1'b0;
        presc_write <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task wait_idle;
        int i;
        for (i = 0; i < 400 && switch_in_progress !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (i == 400) hang("switch");
    endtask
    // Cycles from one peripheral tick to the next
    task period;
        int i;
        for (i = 0; i < 200 && per_clock_en !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (per_clock_en !== 1'b1 && n < 200);
        if (i == 200 || n == 200) hang("tick");
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check_val(main_source_select, mcc_pkg::SEL_HFO, "reset select");
        check_val(presc_div, mcc_pkg::PDIV_RESET, "reset divider");
        period();
        period();
        check_cnt(n, 6, "reset divide");
        // Unprotected write and late write both refused
        @(posedge ref_clk);
        ctrl_write <= 1'b1;
        wr_source_select <= mcc_pkg::SEL_LPO;
        @(posedge ref_clk);
        ctrl_write <= 1'b0;
        prot(1'b1, mcc_pkg::SEL_LPO, 1'b0, 4'h0, 1'b0, 4);
        check_val(main_source_select, mcc_pkg::SEL_HFO, "write without key");
        prot(1'b1, mcc_pkg::SEL_LPO, 1'b0, 4'h0, 1'b0, 0);
        check_val(switch_in_progress, 1'b1, "pending flag");
        wait_idle();
        check_val(main_source_active, mcc_pkg::SEL_LPO, "low power main");
        check_val(lpo_stable, 1'b1, "low power stable");
        prot(1'b1, mcc_pkg::SEL_HFO, 1'b1, 4'h0, 1'b0, 3);
        wait_idle();
        check_val(main_source_active, mcc_pkg::SEL_HFO, "back to fast");
        check_val(hfo_stable, 1'b1, "fast stable");
        check_val(clock_output_oe, 1'b1, "clock out enable");
        period();
        v = clock_output_pin;
        period();
        check_val(clock_output_pin, !v, "clock out toggle");
        // Every divider code, then divide by one
        for (c = 0; c < 13; c++) begin
            prot(1'b0, 2'h0, 1'b0, c[3:0] % 4'hc, c < 12, 0);
            period();
            period();
            check_cnt(n, exp_div(c[3:0] % 4'hc, c < 12), "divide");
        end
        prot(1'b0, 2'h0, 1'b0, 4'h8, 1'b1, 0);
        // Random demand and sleep modes
        for (c = 0; c < 60; c++) begin
            @(posedge ref_clk);
            lfsr = lfsr_next(lfsr);
            dem <= lfsr[9:0];
            sleep_mode <= lfsr[11:10];
            nvm_busy <= lfsr[12];
            #1;
            check_val({ext_pin_clock_mode, rtc_clock_req, watchdog_clock_req, brownout_clock_req},
                exp_req(dem), "clock requests");
        end
        @(posedge ref_clk);
        dem <= 10'h0;
        sleep_mode <= 2'h0;
        nvm_busy <= 1'b0;
        // External switch with the pin silent, then running, then failing
        prot(1'b1, mcc_pkg::SEL_EXT, 1'b1, 4'h0, 1'b0, 0);
        check_val(ext_pin_clock_mode, 1'b1, "pin in clock mode");
        prot(1'b1, mcc_pkg::SEL_HFO, 1'b1, 4'h0, 1'b0, 0);
        check_val(main_source_select, mcc_pkg::SEL_EXT, "select locked");
        repeat (30) @(posedge ref_clk);
        #1;
        check_val(main_source_active, mcc_pkg::SEL_HFO, "old clock kept");
        check_val(external_clock_stable, 1'b0, "silent pin unstable");
        @(posedge ref_clk);
        ext_run <= 1'b1;
        wait_idle();
        check_val(main_source_active, mcc_pkg::SEL_EXT, "external main");
        check_val(external_clock_stable, 1'b1, "external stable");
        @(posedge ref_clk);
        ext_run <= 1'b0;
        repeat (30) @(posedge ref_clk);
        #1;
        check_val(main_source_active, mcc_pkg::SEL_EXT, "no fallback");
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check_val(main_source_active, mcc_pkg::SEL_HFO, "reset recovers");
        check_val(presc_div, mcc_pkg::PDIV_RESET, "reset divider again");
        conclude();
    end
endmodule
